// [src/rtb_timebase.sv]
// Purpose: Oscillator select, divider chain, tick hold-off, watchdog, crystal calibration.
// Assumes: Oscillator and supply pins are asynchronous; burst flag is on mclk.
// Notes: Calendar counters sit outside; this block feeds them ticks and load strobes.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
module rtb_timebase
    import rtb_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic xt_clk_in,
    input wire logic rc_clk_in,
    input wire logic vcc_low_in,
    input wire logic xt_fail_in,
    input wire logic wdog_kick_input,
    input wire logic counter_burst,
    output logic tick_100hz,
    output logic tick_1hz,
    output logic clock_output_pin,
    output logic hundredths_avail,
    output logic rc_active,
    output logic counter_load_pulse,
    output logic [31:0] counter_load_data,
    output logic irq_out_n,
    output logic reset_out_n
);
    localparam int NSYNC = 5;

    function automatic rtb_sel_e reg_sel(input logic [ADDR_W-1:0] a);
        case (a)
            CTRL_OFS: reg_sel = RTB_SEL_CTRL;
            CAL_OFS: reg_sel = RTB_SEL_CAL;
            WDOG_OFS: reg_sel = RTB_SEL_WDOG;
            STATUS_OFS: reg_sel = RTB_SEL_STATUS;
            CTR_WR_OFS: reg_sel = RTB_SEL_CTR;
            default: reg_sel = RTB_SEL_NONE;
        endcase
    endfunction : reg_sel

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    // Pin synchronisers: xt, rc, vcc_low, xt_fail, kick
    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    logic [NSYNC-1:0] sync3_ff;
    assign pins = {wdog_kick_input, xt_fail_in, vcc_low_in, rc_clk_in, xt_clk_in};
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                sync1_ff[i] <= 1'b0;
                sync2_ff[i] <= 1'b0;
                sync3_ff[i] <= 1'b0;
            end else begin
                sync1_ff[i] <= pins[i];
                sync2_ff[i] <= sync1_ff[i];
                sync3_ff[i] <= sync2_ff[i];
            end
        end
    end
    logic xt_rise;
    logic rc_rise;
    logic kick_edge;
    assign xt_rise = sync2_ff[0] & ~sync3_ff[0];
    assign rc_rise = sync2_ff[1] & ~sync3_ff[1];
    assign kick_edge = sync2_ff[4] ^ sync3_ff[4];

    // AXI4-Lite slave
    logic [31:0] ctrl_ff, cal_ff, wdog_ff;
    logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic do_wr;
    rtb_sel_e wsel;
    assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign do_wr = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    assign wsel = reg_sel(awaddr_ff);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= (wsel == RTB_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_ff <= REG_RESET;
            cal_ff <= REG_RESET;
            wdog_ff <= REG_RESET;
        end else if (do_wr) begin
            case (wsel)
                RTB_SEL_CTRL: ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff);
                RTB_SEL_CAL: cal_ff <= merge(cal_ff, wdata_ff, wstrb_ff);
                RTB_SEL_WDOG: wdog_ff <= merge(wdog_ff, wdata_ff, wstrb_ff);
                default: ;
            endcase
        end
    end

    // Counter load strobe toward the calendar counters
    logic ctr_wr_req;
    assign ctr_wr_req = do_wr && wsel == RTB_SEL_CTR;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            counter_load_pulse <= 1'b0;
            counter_load_data <= '0;
        end else begin
            counter_load_pulse <= ctr_wr_req & ctrl_ff[CTRL_CTR_WEN];
            if (ctr_wr_req && ctrl_ff[CTRL_CTR_WEN]) begin
                counter_load_data <= wdata_ff;
            end
        end
    end

    // Oscillator selection
    logic nxt_rc_active;
    logic rc_active_ff, osc_switch;
    assign nxt_rc_active = ctrl_ff[CTRL_OSC_SEL]
        | (ctrl_ff[CTRL_AUTO_SUP] & sync2_ff[2]) | (ctrl_ff[CTRL_FAILOVER] & sync2_ff[3]);
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rc_active_ff <= 1'b0;
        end else begin
            rc_active_ff <= nxt_rc_active;
        end
    end
    assign rc_active = rc_active_ff;
    assign hundredths_avail = ~rc_active_ff;
    // Only sub-second phase is dropped on a switch, so error stays under a second
    assign osc_switch = nxt_rc_active ^ rc_active_ff;

    logic clr_xt, clr_rc;
    assign clr_xt = (counter_load_pulse & ~rc_active_ff) | osc_switch;
    assign clr_rc = (counter_load_pulse & rc_active_ff) | osc_switch;

    // Crystal calibration: phase accumulator spreads pulses over the period
    logic ph_ff, add_pend_ff;
    logic [CAL_ACC_W-1:0] acc_ff;
    logic signed [ADJ_W-1:0] adj;
    logic [ADJ_W-1:0] mag;
    logic [CAL_ACC_W:0] acc_sum;
    logic slot, odd_edge, cal_hit, p16k;
    logic [CAL_OFS_W-1:0] cal_off;
    logic [CAL_EXT_W-1:0] cal_ext;
    assign cal_off = cal_ff[CAL_OFS_LSB +: CAL_OFS_W];
    assign cal_ext = cal_ff[CAL_EXT_LSB +: CAL_EXT_W];
    always_comb begin
        adj = ADJ_W'($signed(cal_off));
        if (cal_ff[CAL_COARSE]) begin
            adj = adj <<< 1;
        end
        adj = adj - ADJ_W'($signed({1'b0, cal_ext, EXT_STEP_SHIFT'(0)}));
        mag = adj[ADJ_W-1] ? ADJ_W'(-adj) : ADJ_W'(adj);
        if (rc_active_ff) begin
            mag = '0;
        end
    end
    assign slot = xt_rise & ph_ff;
    assign odd_edge = xt_rise & ~ph_ff;
    assign acc_sum = {1'b0, acc_ff} + {(CAL_ACC_W + 1 - ADJ_W)'(0), mag};
    assign cal_hit = slot & acc_sum[CAL_ACC_W];
    // Gate on a negative hit; insert the extra pulse at the next odd 32 kHz edge
    assign p16k = (slot & ~(cal_hit & adj[ADJ_W-1])) | (odd_edge & add_pend_ff);
    always_ff @(posedge mclk) begin
        if (sys_rst || clr_xt) begin
            ph_ff <= 1'b0;
            add_pend_ff <= 1'b0;
        end else begin
            if (xt_rise) begin
                ph_ff <= ~ph_ff;
            end
            if (cal_hit && !adj[ADJ_W-1]) begin
                add_pend_ff <= 1'b1;
            end else if (odd_edge) begin
                add_pend_ff <= 1'b0;
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            acc_ff <= '0;
        end else if (slot) begin
            acc_ff <= acc_sum[CAL_ACC_W-1:0];
        end
    end

    // Crystal divider chain down to 100 Hz and 1 Hz
    logic [2:0] c2k_ff;
    logic [4:0] c100_ff, iter_ff;
    logic [6:0] hund_ff, c16x_ff, rc128_ff;
    logic p2k, p100x, p1x, p1r, p16hz;
    logic [4:0] div_last;
    assign p2k = p16k & (c2k_ff == DIV_16K_TO_2K_LAST);
    // Odd iterations divide by 21, even by 20: 12 long and 13 short per 25
    assign div_last = iter_ff[0] ? DIV_LONG_LAST : DIV_SHORT_LAST;
    assign p100x = p2k & (c100_ff == div_last);
    assign p1x = p100x & (hund_ff == HUND_LAST);
    always_ff @(posedge mclk) begin
        if (sys_rst || clr_xt) begin
            c2k_ff <= '0;
            c100_ff <= '0;
            iter_ff <= '0;
        end else begin
            if (p16k) begin
                c2k_ff <= c2k_ff + 3'h1;
            end
            if (p100x) begin
                c100_ff <= '0;
                iter_ff <= (iter_ff == ITER_LAST) ? 5'h00 : iter_ff + 5'h01;
            end else if (p2k) begin
                c100_ff <= c100_ff + 5'h01;
            end
        end
    end
    // Hundredths phase is kept on a counter write; the next 100 Hz tick restarts cleanly
    always_ff @(posedge mclk) begin
        if (sys_rst || osc_switch) begin
            hund_ff <= '0;
        end else if (p100x) begin
            hund_ff <= p1x ? 7'h00 : hund_ff + 7'h01;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            c16x_ff <= '0;
        end else if (p2k) begin
            c16x_ff <= c16x_ff + 7'h01;
        end
    end

    // RC chain: 128 Hz down to 1 Hz
    assign p1r = rc_rise & (rc128_ff == RC_LAST);
    always_ff @(posedge mclk) begin
        if (sys_rst || clr_rc) begin
            rc128_ff <= '0;
        end else if (rc_rise) begin
            rc128_ff <= rc128_ff + 7'h01;
        end
    end
    assign p16hz = rc_active_ff ? (rc_rise & (rc128_ff[2:0] == RC_16HZ_LAST))
                                : (p2k & (c16x_ff == XT_16HZ_LAST));

    // Tick hold-off during counter bursts
    logic raw100, raw1, pend100_ff, pend1_ff;
    assign raw100 = p100x & ~rc_active_ff;
    assign raw1 = rc_active_ff ? p1r : p1x;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pend100_ff <= 1'b0;
            pend1_ff <= 1'b0;
            tick_100hz <= 1'b0;
            tick_1hz <= 1'b0;
        end else begin
            // A held 100 Hz tick is dropped on a switch to RC unless the burst has ended by the first RC cycle
            pend100_ff <= (pend100_ff | raw100) & counter_burst & ~rc_active_ff;
            pend1_ff <= (pend1_ff | raw1) & counter_burst;
            tick_100hz <= ~counter_burst & (pend100_ff | raw100);
            tick_1hz <= ~counter_burst & (pend1_ff | raw1);
        end
    end

    // 1 Hz square wave; a counter write may stretch or shorten one cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clock_output_pin <= 1'b0;
        end else begin
            clock_output_pin <= rc_active_ff ? (rc128_ff < RC_HALF) : (hund_ff < HUND_HALF);
        end
    end

    // Watchdog
    logic [WD_MULT_W-1:0] wd_mult, wd_cnt_ff;
    logic [WD_RATE_W-1:0] wd_rate;
    logic [5:0] wd_pre_ff, wd_mask;
    logic wd_run_ff, wd_write, wd_restart, wd_tick, wd_timeout;
    logic wd_flag_ff, rst_pend_ff, rst_act_ff, st_clear, wd_write_d_ff;
    assign wd_mult = wdog_ff[WD_MULT_LSB +: WD_MULT_W];
    assign wd_rate = wdog_ff[WD_RATE_LSB +: WD_RATE_W];
    always_comb begin
        case (wd_rate)
            2'b00: wd_mask = WD_MASK_16HZ;
            2'b01: wd_mask = WD_MASK_4HZ;
            2'b10: wd_mask = WD_MASK_1HZ;
            default: wd_mask = WD_MASK_QHZ;
        endcase
    end
    assign wd_write = do_wr && wsel == RTB_SEL_WDOG;
    // Restart a cycle after the write, once wdog_ff holds the new multiplier
    assign wd_restart = wd_write_d_ff | (kick_edge & wd_run_ff);
    assign wd_tick = p16hz & (wd_pre_ff == wd_mask);
    assign wd_timeout = wd_run_ff & wd_tick & (wd_cnt_ff == WD_MULT_W'(1));
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wd_cnt_ff <= '0;
            wd_pre_ff <= '0;
            wd_run_ff <= 1'b0;
        end else if (wd_restart) begin
            wd_cnt_ff <= wd_mult;
            wd_pre_ff <= '0;
            wd_run_ff <= 1'b1;
        end else begin
            if (wd_cnt_ff == '0) begin
                wd_run_ff <= 1'b0;
            end
            if (p16hz) begin
                wd_pre_ff <= (wd_pre_ff == wd_mask) ? 6'h00 : wd_pre_ff + 6'h01;
            end
            if (wd_run_ff && wd_tick) begin
                wd_cnt_ff <= wd_cnt_ff - WD_MULT_W'(1);
            end
            if (wd_timeout) begin
                wd_run_ff <= 1'b0;
            end
        end
    end
    // Write strobe delayed to the cycle in which the new field stands
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wd_write_d_ff <= 1'b0;
        end else begin
            wd_write_d_ff <= wd_write;
        end
    end

    assign st_clear = do_wr && wsel == RTB_SEL_STATUS && wstrb_ff[0] && !wdata_ff[ST_WD_FLAG];
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wd_flag_ff <= 1'b0;
        end else if (wd_timeout) begin
            wd_flag_ff <= 1'b1;
        end else if (st_clear) begin
            wd_flag_ff <= 1'b0;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= ~(wd_flag_ff & ~wdog_ff[WD_STEER]);
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rst_pend_ff <= 1'b0;
            rst_act_ff <= 1'b0;
        end else begin
            if (wd_timeout && wdog_ff[WD_STEER]) begin
                rst_pend_ff <= 1'b1;
            end else if (p16hz && rst_pend_ff) begin
                rst_pend_ff <= 1'b0;
            end
            if (p16hz) begin
                rst_act_ff <= rst_pend_ff;
            end
        end
    end
    assign reset_out_n = ~rst_act_ff;

    // Read path
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            case (reg_sel(s_axi_araddr))
                RTB_SEL_CTRL: rdata_ff <= ctrl_ff;
                RTB_SEL_CAL: rdata_ff <= cal_ff;
                RTB_SEL_WDOG: rdata_ff <= wdog_ff;
                RTB_SEL_STATUS: rdata_ff <= {28'h0, sync2_ff[3], sync2_ff[2], rc_active_ff,
                                             wd_flag_ff};
                RTB_SEL_CTR: rdata_ff <= counter_load_data;
                default: begin
                    rdata_ff <= '0;
                    rresp_ff <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    AST_RC_NO_HUND: assert property (rc_active_ff && $past(rc_active_ff) |=> !tick_100hz)
        else $error("100 Hz tick while RC selected");
    AST_HOLD_OFF: assert property (counter_burst |=> !tick_100hz && !tick_1hz)
        else $error("tick during counter burst");
    AST_RELEASE: assert property (pend100_ff && !counter_burst |=> tick_100hz)
        else $error("held 100 Hz tick lost");
    AST_CTR_BLOCK: assert property (ctr_wr_req && !ctrl_ff[CTRL_CTR_WEN] |=> !counter_load_pulse)
        else $error("counter write not blocked");
    AST_CHAIN_CLR: assert property (counter_load_pulse && !rc_active_ff |=> c2k_ff == 3'h0
        && c100_ff == 5'h00 && iter_ff == 5'h00)
        else $error("divider chain not cleared");
    AST_DIV_SEQ: assert property (p100x |-> (c100_ff == DIV_LONG_LAST) == iter_ff[0])
        else $error("wrong 100 Hz divide");
    AST_WD_FLAG: assert property (wd_timeout |=> wd_flag_ff && !wd_run_ff)
        else $error("watchdog flag or stop missing");
    AST_WD_RELOAD: assert property (wd_write |=> ##1 wd_cnt_ff == wd_mult && wd_run_ff)
        else $error("watchdog not reloaded on write");
    AST_WD_KICK: assert property (kick_edge && wd_run_ff && !wd_write
        |=> wd_cnt_ff == wd_mult)
        else $error("watchdog not restarted by kick");
    AST_WD_IRQ: assert property (wd_timeout && !wdog_ff[WD_STEER] |=> ##1 !irq_out_n)
        else $error("watchdog interrupt missing");
    AST_RST_HOLD: assert property ($rose(rst_act_ff) |-> rst_act_ff until p16hz)
        else $error("reset output released early");
    AST_CAL_OFF: assert property (rc_active_ff |-> p16k == slot)
        else $error("calibration active in RC mode");
endmodule : rtb_timebase

// [src/rtb_pkg.sv]
// Purpose: Constants for the timebase, watchdog and crystal calibration block.
// Assumes: mclk at 250 MHz; oscillator clocks arrive as slow pins.
// Notes: Register offsets are byte addresses on AXI4-Lite.
// Overview of operation
// - Select bit picks RC timebase; switch error small.
// - Auto switch to RC on low supply/crystal fault.
// - Burst access holds off 1 Hz, 100 Hz.
// - Counter write clears divider chain below tick.
// - Next tick one full period after write.
// - Square wave may show one odd cycle.
// - Counter writes need counter write enable bit.
// - 100 Hz from 2 kHz: alternate 21/20 divide.
// - No hundredths while RC timebase is selected.
// - Watchdog rate select; restart reloads multiplier.
// - Timeout drives interrupt or reset per steering.
// - Timeout sets flag; software writes zero clears.
// - Reset output within 1/16 s, held 1/16 s.
// - Register write restarts watchdog; kick edge only while it runs.
// - Stopped after timeout; zero multiplier disables.
// - Rate code 01 gives 250 ms ticks.
// - Calibration gates/adds 16 kHz pulses per period.
// - Offset is two's complement, -64 to +63.
// - Extended field slows by 122 ppm steps.
// - Pulses spread evenly, jitter one 16 kHz period.
package rtb_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CAL_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] WDOG_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] CTR_WR_OFS = 8'h10;
    typedef enum logic [2:0] {
        RTB_SEL_CTRL, RTB_SEL_CAL, RTB_SEL_WDOG, RTB_SEL_STATUS, RTB_SEL_CTR, RTB_SEL_NONE
    } rtb_sel_e;
    // Control fields
    localparam int CTRL_OSC_SEL = 0;
    localparam int CTRL_AUTO_SUP = 1;
    localparam int CTRL_FAILOVER = 2;
    localparam int CTRL_CTR_WEN = 3;
    // Calibration fields
    localparam int CAL_OFS_LSB = 0;
    localparam int CAL_OFS_W = 7;
    localparam int CAL_COARSE = 7;
    localparam int CAL_EXT_LSB = 8;
    localparam int CAL_EXT_W = 2;
    // Watchdog fields
    localparam int WD_RATE_LSB = 0;
    localparam int WD_RATE_W = 2;
    localparam int WD_MULT_LSB = 2;
    localparam int WD_MULT_W = 5;
    localparam int WD_STEER = 7;
    // Status fields
    localparam int ST_WD_FLAG = 0;
    localparam int ST_RC_ACT = 1;
    localparam int ST_VCC_LOW = 2;
    localparam int ST_XT_FAIL = 3;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    // Divider chain
    localparam logic [2:0] DIV_16K_TO_2K_LAST = 3'h7;
    localparam logic [4:0] DIV_LONG_LAST = 5'd20;
    localparam logic [4:0] DIV_SHORT_LAST = 5'd19;
    localparam logic [4:0] ITER_LAST = 5'd24;
    localparam logic [6:0] HUND_LAST = 7'd99;
    localparam logic [6:0] HUND_HALF = 7'd50;
    localparam logic [6:0] RC_LAST = 7'd127;
    localparam logic [6:0] RC_HALF = 7'd64;
    localparam logic [2:0] RC_16HZ_LAST = 3'h7;
    localparam logic [6:0] XT_16HZ_LAST = 7'd127;
    localparam int CAL_ACC_W = 19;
    localparam int ADJ_W = 10;
    localparam int EXT_STEP_SHIFT = 6;
    // Watchdog prescale masks on the 16 Hz tick
    localparam logic [5:0] WD_MASK_16HZ = 6'h00;
    localparam logic [5:0] WD_MASK_4HZ = 6'h03;
    localparam logic [5:0] WD_MASK_1HZ = 6'h0f;
    localparam logic [5:0] WD_MASK_QHZ = 6'h3f;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : rtb_pkg

// [verification/rtb_osc_model.sv]
// Purpose: Crystal and RC oscillator sources for the timebase bench.
// Assumes: Crystal runs far faster than real so 100 Hz fits the run.
// Notes: RC keeps the 256:1 ratio to the crystal.
module rtb_osc_model #(
    parameter int XT_HALF_NS = 16,
    parameter int RC_HALF_NS = 4096
) (
    output logic xt_clk,
    output logic rc_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        xt_clk = 1'b0;
        forever #(XT_HALF_NS) xt_clk = ~xt_clk;
    end
    initial begin
        rc_clk = 1'b0;
        forever #(RC_HALF_NS) rc_clk = ~rc_clk;
    end
endmodule : rtb_osc_model

// [verification/rtb_timebase_tb.sv]
// Purpose: Self-checking bench for rtb_timebase.
// Assumes: 2 kHz stage is 128 mclk with the fast crystal model.
// Notes: Watchdog runs at the fastest rate so a timeout fits the run.
module rtb_timebase_tb import rtb_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, sys_rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0;
    logic arv = 1'b0, rry = 1'b0, vcc_low = 1'b0, burst = 1'b0, kick = 1'b0, xtf = 1'b0;
    logic [ADDR_W-1:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd, ldd, d;
    logic [3:0] ws = 4'h0;
    logic awr, wr, bv, arr, rv, t100, t1, sq, hav, rca, ldp, irq_n, rst_n, xt, rc;
    logic [1:0] br, rr, r;
    int n_fail = 0, n_checks = 0, cyc = 0, n_tick = 0, n_load = 0, t_load = 0, t_tick = 0, c;
    rtb_osc_model rtb_osc_model_i (.xt_clk(xt), .rc_clk(rc));
    rtb_timebase rtb_timebase_i (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .xt_clk_in(xt), .rc_clk_in(rc), .vcc_low_in(vcc_low), .xt_fail_in(xtf),
        .wdog_kick_input(kick), .counter_burst(burst), .tick_100hz(t100), .tick_1hz(t1),
        .clock_output_pin(sq), .hundredths_avail(hav), .rc_active(rca),
        .counter_load_pulse(ldp), .counter_load_data(ldd), .irq_out_n(irq_n),
        .reset_out_n(rst_n));
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (t100 === 1'b1) begin
            n_tick <= n_tick + 1;
            t_tick <= cyc;
        end
        if (ldp === 1'b1) begin
            n_load <= n_load + 1;
            t_load <= cyc;
        end
        if (cyc == 100000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end
    task print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] e, input logic [31:0] g, input string s);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s exp %h seen %h", s, e, g);
        end
    endtask : chk
    // Release each channel only at the edge that takes it
    task axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge mclk);
        awa <= a; wd <= v; ws <= 4'hf; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        do begin
            @(posedge mclk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
            if (bv === 1'b1 && bry === 1'b1) begin
                resp = br;
                bry <= 1'b0;
            end
        end while (awv | wv | bry);
    endtask : axw
    task axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge mclk);
        ara <= a; arv <= 1'b1; rry <= 1'b1;
        do begin
            @(posedge mclk);
            if (arr === 1'b1) arv <= 1'b0;
            if (rv === 1'b1 && rry === 1'b1) begin
                v = rd;
                resp = rr;
                rry <= 1'b0;
            end
        end while (arv | rry);
    endtask : axr
    task wait_tick();
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (t100 !== 1'b1 && k < 5000);
        @(posedge mclk);
    endtask : wait_tick
    task t_regs();
        axr(CTRL_OFS, d, r);
        chk(REG_RESET, d, "ctrl reset");
        axr(8'h14, d, r);
        chk(RESP_SLVERR, r, "read unmapped");
        axw(8'h14, 32'h1, r);
        chk(RESP_SLVERR, r, "write unmapped");
        axw(CAL_OFS, 32'h3ff, r);
        axr(CAL_OFS, d, r);
        chk(32'h3ff, d, "cal readback");
        axw(CAL_OFS, 32'h0, r);
        $display("t_regs done");
    endtask : t_regs
    task t_ctr();
        c = n_load;
        axw(CTR_WR_OFS, 32'h1234, r);
        repeat (6) @(posedge mclk);
        chk(c, n_load, "blocked load");
        axw(CTRL_OFS, 32'h8, r);
        axw(CTR_WR_OFS, 32'h5678, r);
        repeat (6) @(posedge mclk);
        chk(c + 1, n_load, "load");
        chk(32'h5678, ldd, "load data");
        wait_tick();
        chk(1, (t_tick - t_load) inside {[2420:2570]}, "tick after load");
        $display("t_ctr done");
    endtask : t_ctr
    task t_div();
        wait_tick();
        c = t_tick;
        wait_tick();
        chk(1, (t_tick - c) inside {[2559:2561], [2687:2689]}, "100 Hz period");
        $display("t_div done");
    endtask : t_div
    task t_burst();
        wait_tick();
        c = n_tick;
        burst <= 1'b1;
        repeat (3000) @(posedge mclk);
        chk(c, n_tick, "held tick");
        burst <= 1'b0;
        repeat (5) @(posedge mclk);
        chk(c + 1, n_tick, "released tick");
        $display("t_burst done");
    endtask : t_burst
    task t_wdog();
        axw(WDOG_OFS, 32'h04, r);
        kick <= 1'b1;
        c = 0;
        while (irq_n !== 1'b0 && c < 40000) begin
            @(posedge mclk);
            c++;
        end
        chk(0, irq_n, "irq out");
        chk(1, rst_n, "reset out");
        axr(STATUS_OFS, d, r);
        chk(1, d[ST_WD_FLAG], "timeout flag");
        axw(STATUS_OFS, 32'h0, r);
        repeat (4) @(posedge mclk);
        chk(1, irq_n, "irq cleared");
        axw(WDOG_OFS, 32'h84, r);
        c = 0;
        while (rst_n !== 1'b0 && c < 40000) begin
            @(posedge mclk);
            c++;
        end
        chk(1, irq_n, "irq steered off");
        c = 0;
        while (rst_n === 1'b0 && c < 20000) begin
            @(posedge mclk);
            c++;
        end
        chk(1, c inside {[16383:16385]}, "reset hold");
        $display("t_wdog done");
    endtask : t_wdog
    task t_rc();
        axw(CTRL_OFS, 32'h2, r);
        repeat (8) @(posedge mclk);
        chk(0, rca, "rc idle");
        vcc_low <= 1'b1;
        repeat (8) @(posedge mclk);
        chk(1, rca, "auto rc");
        vcc_low <= 1'b0;
        axw(CTRL_OFS, 32'h4, r);
        xtf <= 1'b1;
        repeat (8) @(posedge mclk);
        chk(1, rca, "failover rc");
        axw(CTRL_OFS, 32'h1, r);
        repeat (8) @(posedge mclk);
        chk(1, rca, "rc select");
        chk(0, hav, "hundredths");
        c = n_tick;
        repeat (3000) @(posedge mclk);
        chk(c, n_tick, "no 100 Hz");
        $display("t_rc done");
    endtask : t_rc
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_ctr();
        t_div();
        t_burst();
        t_wdog();
        t_rc();
        print_verdict();
    end
endmodule : rtb_timebase_tb
